/* rtl/joystick_regs_pkg.sv */
// Register map, field layout, reset values and states of the joystick control block
package joystick_regs_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_MFR_ID    = 8'h0c;
  localparam logic [7:0] ADDR_COMP_VER  = 8'h0d;
  localparam logic [7:0] ADDR_SI_REV    = 8'h0e;
  localparam logic [7:0] ADDR_MAIN_CTRL = 8'h0f;
  localparam logic [7:0] ADDR_X_RES     = 8'h10;
  localparam logic [7:0] ADDR_Y_RES     = 8'h11;
  localparam logic [7:0] ADDR_LIM_BASE  = 8'h12;
  localparam logic [7:0] ADDR_SCALE     = 8'h2d;
  localparam logic [7:0] ADDR_TRIM      = 8'h2e;

  // Main control field positions
  localparam int CTRL_IDLE_BIT  = 7;
  localparam int CTRL_TB_MSB    = 6;
  localparam int CTRL_TB_LSB    = 4;
  localparam int CTRL_MASK_BIT  = 3;
  localparam int CTRL_FUNC_BIT  = 2;
  localparam int CTRL_SRST_BIT  = 1;
  localparam int CTRL_VALID_BIT = 0;

  // Reset values
  localparam logic       RST_IDLE    = 1'b1;
  localparam logic [2:0] RST_TB      = 3'h7;
  localparam logic       RST_MASK    = 1'b0;
  localparam logic       RST_FUNC    = 1'b0;
  localparam logic [7:0] RST_RESULT  = 8'h00;
  localparam logic [7:0] RST_POS_LIM = 8'h05;
  localparam logic [7:0] RST_NEG_LIM = 8'hfb;
  localparam logic [7:0] RST_SCALE   = 8'h09;
  localparam logic [7:0] RST_TRIM    = 8'h84;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Scaling and serial framing
  localparam int         SCALE_SHIFT = 3;
  localparam int         NUM_LIMITS  = 4;
  localparam logic [3:0] BYTE_BITS   = 4'h8;

  // Serial slave states
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ACK_ADDR = 9'h004,
    ST_REG      = 9'h008,
    ST_ACK_REG  = 9'h010,
    ST_WDATA    = 9'h020,
    ST_ACK_WR   = 9'h040,
    ST_RDATA    = 9'h080,
    ST_ACK_RD   = 9'h100
  } i2c_state_e;

endpackage

/* rtl/joystick_axis_scaler.sv */
// Scales raw axis values to signed 8-bit results and compares them with the limits
`timescale 1ns/10ps
`default_nettype none
module joystick_axis_scaler
  import joystick_regs_pkg::*;
#(
  parameter int RAW_W = 12
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_valid,
  input  wire logic signed [RAW_W-1:0] i_raw_x,
  input  wire logic signed [RAW_W-1:0] i_raw_y,
  input  wire logic [7:0]              i_scale,
  input  wire logic [7:0]              i_pos_h,
  input  wire logic [7:0]              i_neg_h,
  input  wire logic [7:0]              i_pos_v,
  input  wire logic [7:0]              i_neg_v,
  output logic                         o_valid,
  output logic [7:0]                   o_x,
  output logic [7:0]                   o_y,
  output logic                         o_outside
);

  generate
    if (RAW_W < 8 || RAW_W > 16) begin : g_bad_width
      $error("RAW_W must lie between 8 and 16");
    end
  endgenerate

  logic signed [RAW_W-1:0] raw [2];
  logic        [7:0]       sat [2];
  logic                    outside;

  assign raw[0] = i_raw_x;
  assign raw[1] = i_raw_y;

  generate
    for (genvar a = 0; a < 2; a++) begin : g_axis
      logic signed [RAW_W+8:0] prod;
      logic signed [RAW_W+8:0] shifted;
      // Scale by the programmed factor in eighths (shift right by 3), then clamp to the 8-bit range
      assign prod    = raw[a] * $signed({1'b0, i_scale});
      assign shifted = prod >>> SCALE_SHIFT;
      assign sat[a]  = (shifted > 8'sh7f) ? 8'h7f :
                       (shifted < 8'sh80) ? 8'h80 : shifted[7:0];
    end
  endgenerate

  // Outside any of the four limits
  assign outside = ($signed(sat[0]) > $signed(i_pos_h)) ||
                   ($signed(sat[0]) < $signed(i_neg_h)) ||
                   ($signed(sat[1]) > $signed(i_pos_v)) ||
                   ($signed(sat[1]) < $signed(i_neg_v));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid   <= 1'b0;
      o_x       <= RST_RESULT;
      o_y       <= RST_RESULT;
      o_outside <= 1'b0;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        o_x       <= sat[0];
        o_y       <= sat[1];
        o_outside <= outside;
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/joystick_xy_control_regs.sv */
// Serial-reached control, limit and result registers of the two-axis joystick sensor
`timescale 1ns/10ps
`default_nettype none
module joystick_xy_control_regs
  import joystick_regs_pkg::*;
#(
  parameter int         RAW_W        = 12,
  parameter logic [6:0] DEV_ADDR     = 7'h2a, // Value is arbitrary
  parameter logic [7:0] MFR_ID_VAL   = 8'h5a, // Value is arbitrary
  parameter logic [7:0] COMP_VER_VAL = 8'h31, // Value is arbitrary
  parameter logic [7:0] SI_REV_VAL   = 8'h01  // Value is arbitrary
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_scl,
  input  wire logic                    i_sda,
  output logic                         o_sda,
  output logic                         o_sda_oe,
  input  wire logic                    i_calc_start,
  input  wire logic                    i_calc_done,
  input  wire logic signed [RAW_W-1:0] i_raw_x,
  input  wire logic signed [RAW_W-1:0] i_raw_y,
  output logic                         o_idle_mode,
  output logic [2:0]                   o_lp_timebase,
  output logic [7:0]                   o_trim_ctrl,
  output logic                         o_motion_irq_n,
  output logic                         o_motion_irq_n_oe
);

  // Line sampling and bus conditions
  logic scl_q;
  logic sda_q;
  wire  scl_rise  = i_scl & ~scl_q;
  wire  scl_fall  = ~i_scl & scl_q;
  wire  bus_start = scl_q & i_scl & sda_q & ~i_sda;
  wire  bus_stop  = scl_q & i_scl & ~sda_q & i_sda;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end
  // Slave state
  i2c_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] ptr_q, ptr_d;
  logic       oe_q, oe_d;
  logic       rw_q, rw_d;
  logic       nack_q, nack_d;
  logic       rd_y_q, rd_y_d;
  logic       wr_en;
  logic       y_ack_done;
  // Register storage
  logic       idle_q;
  logic [2:0] tb_q;
  logic       mask_q;
  logic       func_q;
  logic       valid_q;
  logic [7:0] x_q;
  logic [7:0] y_q;
  logic [7:0] scale_q;
  logic [7:0] trim_q;
  logic [7:0] lim_q [NUM_LIMITS];
  logic       irq_flag_q;
  logic       irq_oe_q;
  // Scaler results
  logic       sc_valid;
  logic [7:0] sc_x;
  logic [7:0] sc_y;
  logic       sc_outside;
  // Read selection
  wire [7:0] ctrl_rd = {idle_q, tb_q, mask_q, func_q, 1'b0, valid_q};
  wire       lim_hit = (ptr_q >= ADDR_LIM_BASE) &&
                       (ptr_q < ADDR_LIM_BASE + 8'(NUM_LIMITS));
  wire [1:0] lim_idx = 2'(ptr_q - ADDR_LIM_BASE);
  wire [7:0] rd_data =
      (ptr_q == ADDR_MFR_ID)    ? MFR_ID_VAL   :
      (ptr_q == ADDR_COMP_VER)  ? COMP_VER_VAL :
      (ptr_q == ADDR_SI_REV)    ? SI_REV_VAL   :
      (ptr_q == ADDR_MAIN_CTRL) ? ctrl_rd      :
      (ptr_q == ADDR_X_RES)     ? x_q          :
      (ptr_q == ADDR_Y_RES)     ? y_q          :
      lim_hit                   ? lim_q[lim_idx] :
      (ptr_q == ADDR_SCALE)     ? scale_q      :
      (ptr_q == ADDR_TRIM)      ? trim_q       : UNMAPPED_RD;
  // Serial slave next-state logic
  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    sh_d       = sh_q;
    tx_d       = tx_q;
    ptr_d      = ptr_q;
    oe_d       = oe_q;
    rw_d       = rw_q;
    nack_d     = nack_q;
    rd_y_d     = rd_y_q;
    wr_en      = 1'b0;
    y_ack_done = 1'b0;
    if (bus_start) begin
      st_d  = ST_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else if (bus_stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      if (scl_rise) begin
        if (st_q == ST_ADDR || st_q == ST_REG || st_q == ST_WDATA) begin
          sh_d  = {sh_q[6:0], i_sda};
          cnt_d = cnt_q + 4'h1;
        end
        if (st_q == ST_RDATA) begin
          cnt_d = cnt_q + 4'h1;
        end
        if (st_q == ST_ACK_RD) begin
          nack_d = i_sda;
        end
      end
      if (scl_fall) begin
        unique case (st_q)
          ST_IDLE: begin
            oe_d = 1'b0;
          end
          ST_ADDR: begin
            if (cnt_q == BYTE_BITS) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                rw_d = sh_q[0];
                oe_d = 1'b1;
                st_d = ST_ACK_ADDR;
              end else begin
                st_d = ST_IDLE;
              end
            end
          end
          ST_ACK_ADDR: begin
            cnt_d = 4'h0;
            if (rw_q) begin
              tx_d   = rd_data;
              oe_d   = ~rd_data[7];
              rd_y_d = (ptr_q == ADDR_Y_RES);
              ptr_d  = ptr_q + 8'h01;
              st_d   = ST_RDATA;
            end else begin
              oe_d = 1'b0;
              st_d = ST_REG;
            end
          end
          ST_REG: begin
            if (cnt_q == BYTE_BITS) begin
              ptr_d = sh_q;
              oe_d  = 1'b1;
              st_d  = ST_ACK_REG;
            end
          end
          ST_ACK_REG, ST_ACK_WR: begin
            cnt_d = 4'h0;
            oe_d  = 1'b0;
            st_d  = ST_WDATA;
          end
          ST_WDATA: begin
            if (cnt_q == BYTE_BITS) begin
              wr_en = 1'b1;
              ptr_d = ptr_q + 8'h01;
              oe_d  = 1'b1;
              st_d  = ST_ACK_WR;
            end
          end
          ST_RDATA: begin
            if (cnt_q == BYTE_BITS) begin
              oe_d = 1'b0;
              st_d = ST_ACK_RD;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = ~tx_q[6];
            end
          end
          ST_ACK_RD: begin
            y_ack_done = rd_y_q;
            cnt_d      = 4'h0;
            if (nack_q) begin
              oe_d = 1'b0;
              st_d = ST_IDLE;
            end else begin
              tx_d   = rd_data;
              oe_d   = ~rd_data[7];
              rd_y_d = (ptr_q == ADDR_Y_RES);
              ptr_d  = ptr_q + 8'h01;
              st_d   = ST_RDATA;
            end
          end
          default: begin
            oe_d = 1'b0;
            st_d = ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      tx_q   <= 8'h00;
      ptr_q  <= 8'h00;
      oe_q   <= 1'b0;
      rw_q   <= 1'b0;
      nack_q <= 1'b1;
      rd_y_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      tx_q   <= tx_d;
      ptr_q  <= ptr_d;
      oe_q   <= oe_d;
      rw_q   <= rw_d;
      nack_q <= nack_d;
      rd_y_q <= rd_y_d;
    end
  end

  // Write decode
  wire wr_ctrl  = wr_en && (ptr_q == ADDR_MAIN_CTRL);
  wire wr_scale = wr_en && (ptr_q == ADDR_SCALE);
  wire wr_trim  = wr_en && (ptr_q == ADDR_TRIM);
  wire soft_rst = wr_ctrl && sh_q[CTRL_SRST_BIT];
  wire [7:0] ctrl_wd = soft_rst ? {RST_IDLE, RST_TB, RST_MASK, RST_FUNC, 2'h0} : sh_q;
  // Main control fields
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_q <= RST_IDLE;
      tb_q   <= RST_TB;
      mask_q <= RST_MASK;
      func_q <= RST_FUNC;
    end else if (wr_ctrl) begin
      idle_q <= ctrl_wd[CTRL_IDLE_BIT];
      tb_q   <= ctrl_wd[CTRL_TB_MSB:CTRL_TB_LSB];
      mask_q <= ctrl_wd[CTRL_MASK_BIT];
      func_q <= ctrl_wd[CTRL_FUNC_BIT];
    end
  end
  // Scaling and trim
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scale_q <= RST_SCALE;
      trim_q  <= RST_TRIM;
    end else begin
      if (wr_scale || soft_rst) begin
        scale_q <= soft_rst ? RST_SCALE : sh_q;
      end
      if (wr_trim || soft_rst) begin
        trim_q <= soft_rst ? RST_TRIM : sh_q;
      end
    end
  end
  // Limit registers
  generate
    for (genvar i = 0; i < NUM_LIMITS; i++) begin : g_lim
      localparam logic [7:0] LIM_RST = (i % 2 == 0) ? RST_POS_LIM : RST_NEG_LIM;
      wire wr_lim = wr_en && (ptr_q == ADDR_LIM_BASE + 8'(i));
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          lim_q[i] <= LIM_RST;
        end else if (wr_lim || soft_rst) begin
          lim_q[i] <= soft_rst ? LIM_RST : sh_q;
        end
      end
    end
  endgenerate

  joystick_axis_scaler #(
    .RAW_W (RAW_W)
  ) u_scaler (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_valid   (i_calc_done),
    .i_raw_x   (i_raw_x),
    .i_raw_y   (i_raw_y),
    .i_scale   (scale_q),
    .i_pos_h   (lim_q[0]),
    .i_neg_h   (lim_q[1]),
    .i_pos_v   (lim_q[2]),
    .i_neg_v   (lim_q[3]),
    .o_valid   (sc_valid),
    .o_x       (sc_x),
    .o_y       (sc_y),
    .o_outside (sc_outside)
  );

  // Results, readiness and interrupt
  wire irq_set = sc_valid && !mask_q && (!func_q || sc_outside);
  wire irq_d   = soft_rst ? 1'b0 :
                 irq_set  ? 1'b1 :
                 y_ack_done ? 1'b0 : irq_flag_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      x_q     <= RST_RESULT;
      y_q     <= RST_RESULT;
      valid_q <= 1'b0;
    end else begin
      if (sc_valid || soft_rst) begin
        x_q <= soft_rst ? RST_RESULT : sc_x;
        y_q <= soft_rst ? RST_RESULT : sc_y;
      end
      if (i_calc_start || soft_rst) begin
        valid_q <= 1'b0;
      end else if (sc_valid) begin
        valid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_flag_q <= 1'b0;
      irq_oe_q   <= 1'b0;
    end else begin
      irq_flag_q <= irq_d;
      irq_oe_q   <= irq_d && !(wr_ctrl ? sh_q[CTRL_MASK_BIT] : mask_q);
    end
  end

  assign o_sda             = 1'b0;
  assign o_sda_oe          = oe_q;
  assign o_idle_mode       = idle_q;
  assign o_lp_timebase     = tb_q;
  assign o_trim_ctrl       = trim_q;
  assign o_motion_irq_n    = 1'b0;
  assign o_motion_irq_n_oe = irq_oe_q;

endmodule
`default_nettype wire

/* test/joystick_xy_control_regs_chk.sv */
// Port-level checker for the joystick control register block
`timescale 1ns/10ps
`default_nettype none
module joystick_xy_control_regs_chk (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_scl,
  input wire logic       i_calc_done,
  input wire logic       o_sda,
  input wire logic       o_sda_oe,
  input wire logic       o_idle_mode,
  input wire logic [2:0] o_lp_timebase,
  input wire logic [7:0] o_trim_ctrl,
  input wire logic       o_motion_irq_n,
  input wire logic       o_motion_irq_n_oe
);
  localparam int AGE_MAX = 4;
  logic       scl_q;
  logic [3:0] age_q;
  logic [3:0] age_d;
  assign age_d = (scl_q && !i_scl) ? 4'h0 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      age_q <= 4'hf;
    end else begin
      scl_q <= i_scl;
      age_q <= age_d;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_reset_vals;
    $past(i_rst) |-> o_idle_mode && (o_lp_timebase == 3'h7) && (o_trim_ctrl == 8'h84)
      && !o_sda_oe && !o_motion_irq_n_oe;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Outputs differ from reset values");
  property p_irq_rise;
    $rose(o_motion_irq_n_oe) |-> $past(i_calc_done, 2) || (age_q <= AGE_MAX);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("Interrupt raised without a new pair");
  property p_irq_fall;
    $fell(o_motion_irq_n_oe) |-> age_q <= AGE_MAX;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("Interrupt released away from a bus access");
  property p_sda_chg;
    $changed(o_sda_oe) |-> age_q <= AGE_MAX;
  endproperty
  a_sda_chg: assert property (p_sda_chg)
    else $error("Data line changed late after clock fall");
  property p_sda_rose;
    $rose(o_sda_oe) |-> !i_scl;
  endproperty
  a_sda_rose: assert property (p_sda_rose)
    else $error("Data line pulled while clock high");
  property p_oe_hold;
    $rose(o_sda_oe) |=> o_sda_oe [*3];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("Data bit not held");
  property p_ctrl_chg;
    $changed({o_idle_mode, o_lp_timebase, o_trim_ctrl}) |-> age_q <= AGE_MAX;
  endproperty
  a_ctrl_chg: assert property (p_ctrl_chg)
    else $error("Control outputs changed without a write");
  property p_od_low;
    (o_sda == 1'b0) && (o_motion_irq_n == 1'b0);
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("Open-drain value not low");
endmodule
bind joystick_xy_control_regs joystick_xy_control_regs_chk i_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_calc_done(i_calc_done),
  .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_idle_mode(o_idle_mode),
  .o_lp_timebase(o_lp_timebase), .o_trim_ctrl(o_trim_ctrl),
  .o_motion_irq_n(o_motion_irq_n), .o_motion_irq_n_oe(o_motion_irq_n_oe)
);
`default_nettype wire

/* test/joystick_host.sv */
// Two-wire bus host model for the joystick register interface
`timescale 1ns/10ps
`default_nettype none
module joystick_host #(
  parameter logic [6:0] DEV = 7'h2a
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda_low
);
  logic nak_seen = 1'b0;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic lines(input logic s0, input logic s1);
    o_sda_low = s0;
    hold(4);
    o_scl = 1'b1;
    hold(4);
    o_sda_low = s1;
    hold(4);
  endtask
  task automatic start;
    lines(1'b0, 1'b1);
    o_scl = 1'b0;
  endtask
  task automatic stop;
    lines(1'b1, 1'b0);
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    hold(4);
    o_scl = 1'b1;
    hold(4);
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, ack);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [2:0] k;
    start;
    xfer({DEV, 1'b0}, 1'b1, q, k[0]);
    xfer(a, 1'b1, q, k[1]);
    xfer(d, 1'b1, q, k[2]);
    stop;
    nak_seen |= |k;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic [3:0] k;
    start;
    xfer({DEV, 1'b0}, 1'b1, q, k[0]);
    xfer(a, 1'b1, q, k[1]);
    start;
    xfer({DEV, 1'b1}, 1'b1, q, k[2]);
    xfer(8'hff, 1'b1, d, k[3]);
    stop;
    nak_seen |= |k[2:0];
  endtask
endmodule
`default_nettype wire

/* test/joystick_xy_control_regs_bench.sv */
// Self-checking bench for the joystick control register block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module joystick_xy_control_regs_bench
  import joystick_regs_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               calc_start = 1'b0;
  logic               calc_done = 1'b0;
  logic signed [11:0] raw_x = 12'h000;
  logic signed [11:0] raw_y = 12'h000;
  logic               scl, sda_low, sda_oe, sda_val, irq_oe, irq_val, idle, k;
  logic [2:0]         tb;
  logic [7:0]         trim, q;
  int                 err_count = 0;
  int                 checked = 0;
  wire logic          sda_w = (sda_oe ? sda_val : 1'b1) & ~sda_low;
  wire logic          irq_pin = irq_oe ? irq_val : 1'b1;
  localparam logic [7:0] RA [13] = '{ADDR_MFR_ID, ADDR_COMP_VER, ADDR_SI_REV,
    ADDR_MAIN_CTRL, ADDR_X_RES, ADDR_Y_RES, 8'h12, 8'h13, 8'h14, 8'h15,
    ADDR_SCALE, ADDR_TRIM, 8'h30};
  localparam logic [7:0] RE [13] = '{8'h5a, 8'h31, 8'h01, 8'hf0, 8'h00, 8'h00,
    8'h05, 8'hfb, 8'h05, 8'hfb, 8'h09, 8'h84, 8'h00};
  int tx [5] = '{7, 8, -7, 0, 0};
  int ty [5] = '{-6, 0, 0, 8, -7};
  always #2.5 clk = ~clk;
  joystick_xy_control_regs #(.DEV_ADDR(7'h2a)) i_joystick_xy_control_regs (
    .i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_w), .o_sda(sda_val),
    .o_sda_oe(sda_oe), .i_calc_start(calc_start), .i_calc_done(calc_done),
    .i_raw_x(raw_x), .i_raw_y(raw_y), .o_idle_mode(idle), .o_lp_timebase(tb),
    .o_trim_ctrl(trim), .o_motion_irq_n(irq_val), .o_motion_irq_n_oe(irq_oe));
  joystick_host #(.DEV(7'h2a)) i_joystick_host (
    .i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));
  // Expected result with the scaling factor of 6 written below
  function automatic logic [7:0] sc(input int raw);
    int v;
    v = (raw * 6) >>> 3;
    if (v > 127) v = 127;
    if (v < -128) v = -128;
    return v[7:0];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_joystick_host.wr(a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    i_joystick_host.rd(a, q);
    `CHK(q, e)
  endtask
  task automatic pair(input int x, input int y);
    @(negedge clk);
    raw_x = x[11:0];
    raw_y = y[11:0];
    calc_done = 1'b1;
    @(negedge clk);
    calc_done = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic chk_rst;
    for (int i = 0; i < 13; i++) rc(RA[i], RE[i]);
    `CHK({idle, tb, trim}, 12'hf84)
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    results;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk_rst;
    wr(ADDR_SCALE, 8'h06);
    rc(ADDR_SCALE, 8'h06);
    wr(ADDR_TRIM, 8'h84);
    rc(ADDR_TRIM, 8'h84);
    wr(ADDR_X_RES, 8'h55);
    rc(ADDR_X_RES, 8'h00);
    wr(ADDR_MAIN_CTRL, 8'hf1);
    rc(ADDR_MAIN_CTRL, 8'hf0);
    pair(20, -16);
    `CHK(irq_pin, 1'b0)
    rc(ADDR_MAIN_CTRL, 8'hf1);
    rc(ADDR_X_RES, sc(20));
    `CHK(irq_pin, 1'b0)
    rc(ADDR_Y_RES, sc(-16));
    `CHK(irq_pin, 1'b1)
    @(negedge clk);
    calc_start = 1'b1;
    @(negedge clk);
    calc_start = 1'b0;
    rc(ADDR_MAIN_CTRL, 8'hf0);
    pair(400, -400);
    rc(ADDR_X_RES, sc(400));
    rc(ADDR_Y_RES, sc(-400));
    wr(ADDR_MAIN_CTRL, 8'h58);
    `CHK({idle, tb}, 4'h5)
    pair(0, 0);
    `CHK(irq_pin, 1'b1)
    wr(ADDR_MAIN_CTRL, 8'h54);
    for (int i = 0; i < 5; i++) begin
      pair(tx[i], ty[i]);
      `CHK(irq_pin, i == 0)
      rc(ADDR_Y_RES, sc(ty[i]));
    end
    i_joystick_host.start;
    i_joystick_host.xfer({7'h15, 1'b0}, 1'b1, q, k);
    i_joystick_host.stop;
    `CHK(k, 1'b1)
    `CHK(i_joystick_host.nak_seen, 1'b0)
    i_joystick_host.start;
    i_joystick_host.xfer({7'h2a, 1'b0}, 1'b1, q, k);
    i_joystick_host.xfer(8'h14, 1'b1, q, k);
    i_joystick_host.start;
    i_joystick_host.xfer({7'h2a, 1'b1}, 1'b1, q, k);
    i_joystick_host.xfer(8'hff, 1'b0, q, k);
    `CHK(q, 8'h05)
    i_joystick_host.xfer(8'hff, 1'b1, q, k);
    i_joystick_host.stop;
    `CHK(q, 8'hfb)
    pair(8, 0);
    `CHK(irq_pin, 1'b0)
    wr(8'h12, 8'h10);
    rc(8'h12, 8'h10);
    wr(ADDR_MAIN_CTRL, 8'h02);
    `CHK(irq_pin, 1'b1)
    chk_rst;
    results;
  end
endmodule
`default_nettype wire
